/* File: shared/xlat_cap_pkg.sv */
package xlat_cap_pkg;
    localparam logic [7:0]  OFS_XLAT_BASE   = 8'hA8;
    localparam logic [7:0]  OFS_SETUP       = 8'hAC;
    localparam logic [7:0]  OFS_CAP_HDR     = 8'hB0;
    localparam logic [31:0] XLAT_BASE_RST   = 32'h00000000;
    localparam logic [31:0] SETUP_RST       = 32'h00000000;
    localparam logic [31:0] XLAT_BASE_MASK  = 32'hFFFFFFC0;
    localparam logic [31:0] SETUP_LOAD_MASK = 32'hFFFFFFCE;
    localparam logic [31:0] SIZE_MASK_BITS  = 32'h7FFFFFC0;
    localparam int          SETUP_EN_BIT    = 31;
    localparam logic [7:0]  CAP_ID          = 8'h10;
    localparam logic [7:0]  CAP_NEXT        = 8'hD8;
    localparam logic [3:0]  CAP_VERSION     = 4'h1;
    localparam logic [3:0]  PORT_FWD        = 4'h7;
    localparam logic [3:0]  PORT_REV        = 4'h8;
    localparam logic [4:0]  MSG_NUM         = 5'h00;
endpackage

/* File: logic/xlat_cap_regs.sv */
`timescale 1ns/100ps
// Behaviour
// - Translated base bits 31:6 are software writable; bits 5:0 read zero.
// - Only base bits marked active by the setup size mask are used.
// - Setup bit 0 reads zero, memory space; writes ignored.
// - Setup bits 2:1 address width, bit 3 prefetchable; load-writable only.
// - Setup mask bits 30:6 select address bits compared to the window base and replaced by base bits.
// - Setup bit 31 enables window 1; resets to 0; load-writable only.
// - Capability header bits 7:0 read 10h, bits 19:16 read 1h.
// - Bits 15:8 read D8h, pointer to the next capability.
// - Port type bits 23:20: 0111 forward, 1000 reverse.
// - Bit 24 slot implemented: 0 forward, 1 reverse.
module xlat_cap_regs (
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    input  wire logic        LOAD_WR,
    input  wire logic [31:0] LOAD_DATA,
    input  wire logic        REVERSE_MODE,
    input  wire logic        IN_VALID,
    input  wire logic [31:0] IN_ADDR,
    input  wire logic [31:0] WIN_BASE,
    output logic      [31:0] OUT_ADDR,
    output logic             OUT_HIT,
    output logic             OUT_VALID,
    output logic      [31:0] SETUP_OUT
);

    typedef struct packed {
        logic [31:0] xlat_base;
        logic [31:0] setup;
        logic        rev_s1;
        logic        rev;
        logic [31:0] rdata;
        logic [31:0] out_addr;
        logic        out_hit;
        logic        out_valid;
    } state_s;

    state_s st;
    state_s next_st;

    logic [31:0] size_mask;
    logic [31:0] cap_hdr;
    logic        hit;
    logic [31:0] xlat_addr;
    logic [31:0] bit_diff;
    logic        sel_base;
    logic        sel_setup;
    logic        sel_cap;

    // Per-bit substitution and window compare
    for (genvar b = 0; b < 32; b++) begin : g_xlat_bit
        assign xlat_addr[b] = size_mask[b] ? st.xlat_base[b] : IN_ADDR[b];
        assign bit_diff[b]  = size_mask[b] & (IN_ADDR[b] ^ WIN_BASE[b]);
    end

    always_comb begin
        size_mask = st.setup & xlat_cap_pkg::SIZE_MASK_BITS;
        sel_base  = (ADDR == xlat_cap_pkg::OFS_XLAT_BASE);
        sel_setup = (ADDR == xlat_cap_pkg::OFS_SETUP);
        sel_cap   = (ADDR == xlat_cap_pkg::OFS_CAP_HDR);
        cap_hdr   = {2'h0, xlat_cap_pkg::MSG_NUM, st.rev,
                     st.rev ? xlat_cap_pkg::PORT_REV : xlat_cap_pkg::PORT_FWD,
                     xlat_cap_pkg::CAP_VERSION, xlat_cap_pkg::CAP_NEXT,
                     xlat_cap_pkg::CAP_ID};
        hit       = st.setup[xlat_cap_pkg::SETUP_EN_BIT]
                    && (bit_diff == 32'h00000000);
        next_st        = st;
        next_st.rev_s1 = REVERSE_MODE;
        next_st.rev    = st.rev_s1;
        if (WR && sel_base) begin
            next_st.xlat_base = WDATA & xlat_cap_pkg::XLAT_BASE_MASK;
        end
        if (LOAD_WR) begin
            next_st.setup = LOAD_DATA & xlat_cap_pkg::SETUP_LOAD_MASK;
        end
        next_st.rdata = 32'h00000000;
        if (RD) begin
            case (ADDR)
                xlat_cap_pkg::OFS_XLAT_BASE: next_st.rdata = st.xlat_base;
                xlat_cap_pkg::OFS_SETUP:     next_st.rdata = st.setup;
                xlat_cap_pkg::OFS_CAP_HDR:   next_st.rdata = cap_hdr;
                default:                     next_st.rdata = 32'h00000000;
            endcase
        end
        next_st.out_valid = IN_VALID;
        next_st.out_hit   = IN_VALID && hit;
        next_st.out_addr  = hit ? xlat_addr : IN_ADDR;
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            st.xlat_base <= xlat_cap_pkg::XLAT_BASE_RST;
            st.setup     <= xlat_cap_pkg::SETUP_RST;
            st.rev_s1    <= 1'b0;
            st.rev       <= 1'b0;
            st.rdata     <= 32'h00000000;
            st.out_addr  <= 32'h00000000;
            st.out_hit   <= 1'b0;
            st.out_valid <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign RDATA     = st.rdata;
    assign OUT_ADDR  = st.out_addr;
    assign OUT_HIT   = st.out_hit;
    assign OUT_VALID = st.out_valid;
    assign SETUP_OUT = st.setup;

    AST_SETUP_BIT0_ZERO: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !st.setup[0]) else $error("setup bit 0 not zero");
    AST_BASE_LOW_ZERO: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        st.xlat_base[5:0] == 6'h00) else $error("base low bits set");
    AST_BASE_WRITE: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        WR && ADDR == xlat_cap_pkg::OFS_XLAT_BASE |=> st.xlat_base[31:6] == $past(WDATA[31:6]))
        else $error("base write lost");
    AST_SETUP_SW_RO: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !LOAD_WR |=> $stable(st.setup)) else $error("setup changed without load");
    AST_CAP_READ: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RD && ADDR == xlat_cap_pkg::OFS_CAP_HDR |=> RDATA[7:0] == 8'h10 && RDATA[19:16] == 4'h1)
        else $error("capability id wrong");
    AST_CAP_NEXT: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RD && ADDR == xlat_cap_pkg::OFS_CAP_HDR |=> RDATA[15:8] == 8'hD8) else $error("next ptr wrong");
    AST_PORT_TYPE: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RD && ADDR == xlat_cap_pkg::OFS_CAP_HDR |=> RDATA[23:20] == ($past(st.rev) ? 4'h8 : 4'h7))
        else $error("port type wrong");
    AST_SLOT: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        RD && ADDR == xlat_cap_pkg::OFS_CAP_HDR |=> RDATA[24] == $past(st.rev)) else $error("slot bit wrong");
    AST_DISABLED_NO_HIT: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !st.setup[31] |=> !OUT_HIT) else $error("hit while disabled");
    AST_OFFSET_PASS: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        IN_VALID |=> ((OUT_ADDR ^ $past(IN_ADDR)) & ~$past(size_mask)) == 32'h00000000)
        else $error("offset not passed");

    AST_BASE_READ: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        RD && sel_base
        |=> RDATA == $past(st.xlat_base))
        else $error("base read wrong");

    AST_BASE_RDATA_LOW: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        RD && sel_base
        |=> RDATA[5:0] == 6'h00)
        else $error("base read low bits set");

    AST_BASE_HOLD: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        !WR
        |=> $stable(st.xlat_base))
        else $error("base changed without write");

    AST_BASE_OTHER_ADDR: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        WR && !sel_base
        |=> $stable(st.xlat_base))
        else $error("base changed by other write");

    AST_XLAT_ACTIVE_BITS: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        OUT_HIT
        |-> (OUT_ADDR & $past(size_mask)) == ($past(st.xlat_base) & $past(size_mask)))
        else $error("active base bits not used");

    AST_XLAT_ADDR_FORM: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        OUT_HIT
        |-> OUT_ADDR == (($past(st.xlat_base) & $past(size_mask)) | ($past(IN_ADDR) & ~$past(size_mask))))
        else $error("translated address wrong");

    AST_XLAT_MISS_PASS: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        OUT_VALID && !OUT_HIT
        |-> OUT_ADDR == $past(IN_ADDR))
        else $error("miss address altered");

    AST_VALID_FOLLOW: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        OUT_VALID == $past(IN_VALID))
        else $error("valid not one cycle later");

    AST_HIT_NEEDS_VALID: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        OUT_HIT
        |-> OUT_VALID)
        else $error("hit without valid");

    AST_SETUP_READ_BIT0: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        RD && sel_setup
        |=> !RDATA[0])
        else $error("setup read bit 0 set");

    AST_SETUP_LOAD_BIT0: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        LOAD_WR && LOAD_DATA[0]
        |=> !st.setup[0])
        else $error("setup bit 0 loaded");

    AST_SETUP_WIDTH_LOAD: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        LOAD_WR
        |=> st.setup[2:1] == $past(LOAD_DATA[2:1]))
        else $error("width not loaded");

    AST_SETUP_PREFETCH_LOAD: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        LOAD_WR
        |=> st.setup[3] == $past(LOAD_DATA[3]))
        else $error("prefetch not loaded");

    AST_SETUP_RSVD_ZERO: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        st.setup[5:4] == 2'h0)
        else $error("setup reserved bits set");

    AST_SETUP_SW_WRITE: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        WR && sel_setup && !LOAD_WR
        |=> $stable(st.setup))
        else $error("software write changed setup");

    AST_SETUP_READ: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        RD && sel_setup
        |=> RDATA == $past(st.setup))
        else $error("setup read wrong");

    AST_SETUP_OUT_MIRROR: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        SETUP_OUT == st.setup)
        else $error("setup output differs");

    AST_MASK_LOAD: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        LOAD_WR
        |=> st.setup[30:6] == $past(LOAD_DATA[30:6]))
        else $error("size mask not loaded");

    AST_MASK_MATCH: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        OUT_HIT
        |-> (($past(IN_ADDR) ^ $past(WIN_BASE)) & $past(size_mask)) == 32'h00000000)
        else $error("hit outside window");

    AST_MASK_MISS: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        IN_VALID && (((IN_ADDR ^ WIN_BASE) & size_mask) != 32'h00000000)
        |=> !OUT_HIT)
        else $error("hit on masked mismatch");

    AST_ENABLE_LOAD: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        LOAD_WR
        |=> st.setup[31] == $past(LOAD_DATA[31]))
        else $error("enable not loaded");

    AST_ENABLED_HIT: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        IN_VALID && st.setup[31] && (((IN_ADDR ^ WIN_BASE) & size_mask) == 32'h00000000)
        |=> OUT_HIT)
        else $error("enabled window missed");

    AST_HIT_NEEDS_ENABLE: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        OUT_HIT
        |-> $past(st.setup[31]))
        else $error("hit with window off");

    AST_CAP_ID_PKG: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        RD && sel_cap
        |=> RDATA[7:0] == xlat_cap_pkg::CAP_ID)
        else $error("capability id read wrong");

    AST_CAP_VERSION: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        RD && sel_cap
        |=> RDATA[19:16] == xlat_cap_pkg::CAP_VERSION)
        else $error("capability version wrong");

    AST_CAP_RSVD: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        RD && sel_cap
        |=> RDATA[31:30] == 2'h0)
        else $error("header reserved bits set");

    AST_CAP_MSG: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        RD && sel_cap
        |=> RDATA[29:25] == xlat_cap_pkg::MSG_NUM)
        else $error("message number wrong");

    AST_ID_CONST: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        cap_hdr[7:0] == xlat_cap_pkg::CAP_ID)
        else $error("header id field wrong");

    AST_NEXT_CONST: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        cap_hdr[15:8] == xlat_cap_pkg::CAP_NEXT)
        else $error("header next field wrong");

    AST_REV_SYNC1: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        st.rev_s1 == $past(REVERSE_MODE))
        else $error("mode first stage wrong");

    AST_REV_SYNC2: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        st.rev == $past(st.rev_s1))
        else $error("mode second stage wrong");

    AST_PORT_FWD: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        RD && sel_cap && !st.rev
        |=> RDATA[23:20] == xlat_cap_pkg::PORT_FWD)
        else $error("forward port type wrong");

    AST_PORT_REV: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        RD && sel_cap && st.rev
        |=> RDATA[23:20] == xlat_cap_pkg::PORT_REV)
        else $error("reverse port type wrong");

    AST_SLOT_FWD: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        RD && sel_cap && !st.rev
        |=> !RDATA[24])
        else $error("forward slot bit set");

    AST_SLOT_REV: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        RD && sel_cap && st.rev
        |=> RDATA[24])
        else $error("reverse slot bit clear");

endmodule // xlat_cap_regs

/* File: verif/tb_xlat_cap_regs.sv */
`timescale 1ns/100ps
module tb_xlat_cap_regs;
    logic        CLK_SYS = 0, RST_N = 0, WR = 0, RD = 0, LOAD_WR = 0, REVERSE_MODE = 0, IN_VALID = 0;
    logic [7:0]  ADDR = 0;
    logic [31:0] WDATA = 0, LOAD_DATA = 0, IN_ADDR = 0, WIN_BASE = 0, RDATA, OUT_ADDR, SETUP_OUT, ba, su, wb, ia;
    logic        OUT_HIT, OUT_VALID;
    int          n_errors = 0, comparisons = 0, seed = 32'h23833BBD;
    always #5 CLK_SYS = ~CLK_SYS;
    xlat_cap_regs uut (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .LOAD_WR(LOAD_WR), .LOAD_DATA(LOAD_DATA), .REVERSE_MODE(REVERSE_MODE),
        .IN_VALID(IN_VALID), .IN_ADDR(IN_ADDR), .WIN_BASE(WIN_BASE), .OUT_ADDR(OUT_ADDR),
        .OUT_HIT(OUT_HIT), .OUT_VALID(OUT_VALID), .SETUP_OUT(SETUP_OUT));
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task results;
        $display("Mismatches %0d of %0d comparisons", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK_SYS) {ADDR, WDATA, WR} <= {a, d, 1'b1};
        @(posedge CLK_SYS) WR <= 0;
    endtask
    task ld(input logic [31:0] d);
        @(posedge CLK_SYS) {LOAD_DATA, LOAD_WR} <= {d, 1'b1};
        @(posedge CLK_SYS) LOAD_WR <= 0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge CLK_SYS) {ADDR, RD} <= {a, 1'b1};
        @(posedge CLK_SYS) RD <= 0;
        #1 chk("rdata", RDATA, e);
        @(posedge CLK_SYS) #1 chk("rdata idle", RDATA, 32'h00000000);
    endtask
    function logic [31:0] hdr(input logic r);
        return {2'b0, xlat_cap_pkg::MSG_NUM, r, r ? 4'h8 : 4'h7, 4'h1, 8'hD8, 8'h10};
    endfunction
    task xl(input logic [31:0] a);
        logic [31:0] m;
        logic        h;
        m = su & 32'h7FFFFFC0;
        h = su[31] && ((a ^ wb) & m) == 0;
        @(posedge CLK_SYS) {IN_ADDR, WIN_BASE, IN_VALID} <= {a, wb, 1'b1};
        @(posedge CLK_SYS) IN_VALID <= 0;
        #1 chk("hit", OUT_HIT, h);
        chk("addr", OUT_ADDR, h ? (ba & m) | (a & ~m) : a);
        chk("valid", OUT_VALID, 1);
        @(posedge CLK_SYS) #1 chk("valid idle", OUT_VALID, 0);
    endtask
    // Whole run is a few hundred cycles; this leaves wide margin
    initial begin
        #100000 n_errors++;
        results;
    end
    initial begin
        repeat (8) @(posedge CLK_SYS);
        RST_N <= 1;
        rd(8'hA8, 0);
        rd(8'hAC, 0);
        rd(8'hB0, hdr(0));
        rd(8'hA4, 0);
        $display("Reset values done");
        wr(8'hAC, 32'hFFFFFFFF);
        rd(8'hAC, 0);
        wr(8'hB0, 32'hFFFFFFFF);
        rd(8'hB0, hdr(0));
        $display("Read-only writes done");
        for (int i = 0; i < 16; i++) begin
            {ba, su, wb, ia} = {$random(seed), $random(seed), $random(seed), $random(seed)};
            su = i < 2 ? 32'hFFFFF001 : su & 32'hFFFFF03F;
            wr(8'hA8, ba);
            ba &= 32'hFFFFFFC0;
            ld(su);
            su &= 32'hFFFFFFCE;
            rd(8'hA8, ba);
            rd(8'hAC, su);
            chk("setup", SETUP_OUT, su);
            xl(ia);
            xl(wb ^ (ia & ~su));
        end
        $display("Window translate done");
        @(posedge CLK_SYS) REVERSE_MODE <= 1;
        repeat (3) @(posedge CLK_SYS);
        rd(8'hB0, hdr(1));
        $display("Reverse mode done");
        results;
    end
endmodule // tb_xlat_cap_regs
